/* File: core/dcr_pkg.sv */
package dcr_pkg;
    // Command encodings {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MRS   = 3'h0;
    localparam logic [2:0] CMD_REF   = 3'h1;
    localparam logic [2:0] CMD_PRE   = 3'h2;
    localparam logic [2:0] CMD_ACT   = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ  = 3'h5;
    localparam logic [2:0] CMD_ZQ    = 3'h6;
    localparam logic [2:0] CMD_NOP   = 3'h7;
    // Mode register selects on bank address
    localparam logic [2:0] MR_ZERO  = 3'h0;
    localparam logic [2:0] MR_ONE   = 3'h1;
    localparam logic [2:0] MR_TWO   = 3'h2;
    localparam logic [2:0] MR_THREE = 3'h3;
    // Field positions
    localparam int MR3_READOUT_EN_BIT = 2;
    localparam int MR1_LOOP_OFF_BIT   = 0;
    localparam int CHOP_SELECT_BIT    = 12;
    localparam int NIBBLE_BIT         = 2;
    localparam int AP_BIT             = 10;
    // Burst length field of mode_reg_zero: 00 fixed eight, 01 on the fly, 10 fixed chop
    localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;
    localparam logic [1:0] BL_FIXED_CHOP  = 2'h2;
    // Readout location with defined data
    localparam logic [1:0] LOC_PATTERN = 2'h0;
    // Pattern: burst bit 0 is LSB
    localparam logic [7:0] READOUT_PATTERN = 8'haa;
    // Reset values, loop-off latency and burst beat counts
    localparam logic [1:0] BL_RESET     = 2'h0;
    localparam logic [3:0] LAT_RESET    = 4'h6;
    localparam logic [3:0] LOOP_OFF_LAT = 4'h6;
    localparam int         BEATS_EIGHT  = 8;
    localparam int         BEATS_CHOP   = 4;
endpackage : dcr_pkg

/* File: core/dcr_readout.sv */
`timescale 1ns/100ps
// Function
// - Reads and auto-precharge reads come from the readout register while enabled.
// - Auto-precharge read in readout mode behaves as plain read, no precharge.
// - Reset works while readout mode is enabled.
// - With A2 low, normal array reads and writes regardless of A1, A0.
// - Readout bit drives bit 0 of both lanes; bits 7..1 copy it.
// - Eight-beat order 0..7; chop A2 low gives 0..3, high 4..7.
// - A12 selects chop on the fly if enabled; fixed chop also supported.
// - Other column bits including A10 and bank bits are ignored in readout.
// - Location 00b returns 0,1,0,1 pattern; burst bit 0 is the LSB.
// - Chip select low with strobes high is a no-operation; no command is taken, ongoing operations continue.
// - Chip select high deselects; ongoing operations continue.
// - Mode_reg_one A0 high disables the loop until written back to zero.
// - In loop-off mode a mode_reg_zero write sets cas latency to 6.
// - Loop-off read output starts at additive plus cas latency minus one.
module dcr_readout #(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // Command bus
    input  wire logic              cs_n_in,
    input  wire logic              ras_n_in,
    input  wire logic              cas_n_in,
    input  wire logic              we_n_in,
    input  wire logic [2:0]        bank_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    // Array read data for normal reads
    input  wire logic [15:0]       array_data_in,
    // Data out and array strobes
    output logic      [15:0]       dq_out,
    output logic                   dq_oe_n_out,
    output logic                   array_read_out,
    output logic                   array_write_out,
    output logic                   precharge_out,
    // Status
    output logic                   readout_en_out,
    output logic      [1:0]        readout_loc_out,
    output logic                   loop_off_out,
    output logic      [3:0]        cas_lat_out,
    output logic      [3:0]        add_lat_out
);

    // Decode
    wire logic [2:0] cmd_w       = {ras_n_in, cas_n_in, we_n_in};
    wire logic       sel_w       = !cs_n_in;
    wire logic       is_mrs_w    = sel_w && (cmd_w == dcr_pkg::CMD_MRS);
    wire logic       is_read_w   = sel_w && (cmd_w == dcr_pkg::CMD_READ);
    wire logic       is_write_w  = sel_w && (cmd_w == dcr_pkg::CMD_WRITE);
    wire logic       is_pre_w    = sel_w && (cmd_w == dcr_pkg::CMD_PRE);

    logic            readout_q;
    logic [1:0]      loc_q;
    logic            loop_off_q;
    logic [1:0]      bl_q;
    logic [3:0]      cl_q;
    logic [3:0]      al_q;
    logic [7:0]      shift_q;
    logic [3:0]      beats_q;
    logic [4:0]      delay_q;
    logic            pend_q;
    logic            pend_chop_q;
    logic            pend_nib_q;
    logic            pend_readout_q;

    // Chop decision: on the fly via A12, or fixed
    wire logic chop_w = (bl_q == dcr_pkg::BL_FIXED_CHOP) ||
                        ((bl_q == dcr_pkg::BL_ON_THE_FLY) &&
                         !addr_in[dcr_pkg::CHOP_SELECT_BIT]);
    // Output start: loop-off one cycle earlier
    wire logic [4:0] lat_w = loop_off_q ? 5'(al_q + cl_q - 4'h1)
                                        : 5'(al_q + cl_q);
    wire logic start_w = pend_q && (delay_q <= 5'h1);
    // Pattern slice, nibble selected by A2 for chopped bursts
    wire logic [7:0] pat_w = (loc_q == dcr_pkg::LOC_PATTERN) ?
                             dcr_pkg::READOUT_PATTERN : 8'h00;
    wire logic [7:0] sel_pat_w = (pend_chop_q && pend_nib_q) ?
                                 {4'h0, pat_w[7:4]} : pat_w;
    wire logic [3:0] nbeats_w = pend_chop_q ? 4'(dcr_pkg::BEATS_CHOP)
                                            : 4'(dcr_pkg::BEATS_EIGHT);

    // Mode registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            readout_q  <= 1'b0;
            loc_q      <= 2'h0;
            loop_off_q <= 1'b0;
            bl_q       <= dcr_pkg::BL_RESET;
            cl_q       <= dcr_pkg::LAT_RESET;
            al_q       <= 4'h0;
        end else if (is_mrs_w) begin
            case (bank_in)
                dcr_pkg::MR_ZERO: begin
                    bl_q <= addr_in[1:0];
                    cl_q <= loop_off_q ? dcr_pkg::LOOP_OFF_LAT
                                       : 4'(4 + addr_in[6:4]);
                end
                dcr_pkg::MR_ONE: begin
                    loop_off_q <= addr_in[dcr_pkg::MR1_LOOP_OFF_BIT];
                    al_q       <= (addr_in[4:3] == 2'h0) ? 4'h0 :
                                  4'(cl_q - {2'h0, addr_in[4:3]});
                end
                dcr_pkg::MR_THREE: begin
                    readout_q <= addr_in[dcr_pkg::MR3_READOUT_EN_BIT];
                    loc_q     <= addr_in[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read scheduling and burst
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q         <= 1'b0;
            delay_q        <= 5'h0;
            pend_chop_q    <= 1'b0;
            pend_nib_q     <= 1'b0;
            pend_readout_q <= 1'b0;
            shift_q        <= 8'h00;
            beats_q        <= 4'h0;
            dq_out         <= 16'h0000;
            dq_oe_n_out    <= 1'b1;
        end else begin
            if (is_read_w) begin
                pend_q         <= 1'b1;
                delay_q        <= lat_w;
                pend_chop_q    <= chop_w;
                pend_nib_q     <= addr_in[dcr_pkg::NIBBLE_BIT];
                pend_readout_q <= readout_q;
            end else if (pend_q) begin
                delay_q <= delay_q - 5'h1;
                if (start_w) begin
                    pend_q <= 1'b0;
                end
            end
            if (start_w) begin
                shift_q <= sel_pat_w;
                beats_q <= nbeats_w;
            end else if (beats_q != 4'h0) begin
                shift_q <= {1'b0, shift_q[7:1]};
                beats_q <= beats_q - 4'h1;
            end
            if (beats_q != 4'h0) begin
                dq_oe_n_out <= 1'b0;
                dq_out      <= pend_readout_q ? {2{{8{shift_q[0]}}}}
                                              : array_data_in;
            end else begin
                dq_oe_n_out <= 1'b1;
                dq_out      <= 16'h0000;
            end
        end
    end

    // Array strobes and status
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            array_read_out  <= 1'b0;
            array_write_out <= 1'b0;
            precharge_out   <= 1'b0;
            readout_en_out  <= 1'b0;
            readout_loc_out <= 2'h0;
            loop_off_out    <= 1'b0;
            cas_lat_out     <= dcr_pkg::LAT_RESET;
            add_lat_out     <= 4'h0;
        end else begin
            array_read_out  <= is_read_w && !readout_q;
            array_write_out <= is_write_w && !readout_q;
            precharge_out   <= (is_pre_w ||
                                (is_read_w && addr_in[dcr_pkg::AP_BIT])) &&
                               !readout_q;
            readout_en_out  <= readout_q;
            readout_loc_out <= loc_q;
            loop_off_out    <= loop_off_q;
            cas_lat_out     <= cl_q;
            add_lat_out     <= al_q;
        end
    end

    // Checks
    a_readout_no_array: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && readout_q |=> !array_read_out && !precharge_out)
        else $error("readout read reached array");

    a_rda_no_precharge: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && readout_q && addr_in[10] |=> !precharge_out)
        else $error("precharge in readout mode");

    a_lane_copy: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !dq_oe_n_out && pend_readout_q |-> dq_out[15:8] == dq_out[7:0])
        else $error("byte lanes differ");

    a_normal_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_write_w && !readout_q |=> array_write_out)
        else $error("normal write lost");

    a_nop_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !sel_w || cmd_w == dcr_pkg::CMD_NOP |=> !array_read_out && !array_write_out)
        else $error("command taken while idle");

    a_deselect_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_n_in |=> $stable(readout_q) && $stable(loop_off_q))
        else $error("state changed while deselected");

    a_loop_off_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_mrs_w && bank_in == dcr_pkg::MR_ONE |=> ##1 loop_off_out == $past(addr_in[0], 2))
        else $error("loop control not applied");

    a_loop_off_cl: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_mrs_w && bank_in == dcr_pkg::MR_ZERO && loop_off_q |=> cl_q == 4'h6)
        else $error("loop-off latency not six");

    a_pattern_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        start_w && pend_readout_q && loc_q == 2'h0 |=> ##1 dq_out[0] == 1'b0)
        else $error("pattern first beat wrong");

    a_reset_clear: assert property (@(posedge ref_clk_in)
        !rst_n_in |=> !readout_q)
        else $error("readout survived reset");

    a_readout_status: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_mrs_w && bank_in == dcr_pkg::MR_THREE |=> ##1 readout_en_out == $past(addr_in[2], 2))
        else $error("readout enable not applied");

    a_loc_status: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_mrs_w && bank_in == dcr_pkg::MR_THREE |=> ##1 readout_loc_out == $past(addr_in[1:0], 2))
        else $error("readout location not applied");

    a_chop_beats: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        start_w && pend_chop_q |=> beats_q == 4'h4)
        else $error("chop burst length wrong");

    a_eight_beats: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        start_w && !pend_chop_q |=> beats_q == 4'h8)
        else $error("eight burst length wrong");

    a_fly_chop: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && bl_q == dcr_pkg::BL_ON_THE_FLY && !addr_in[12] |=> pend_chop_q)
        else $error("on the fly chop lost");

    a_fixed_chop: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && bl_q == dcr_pkg::BL_FIXED_CHOP |=> pend_chop_q)
        else $error("fixed chop lost");

    a_nibble_take: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w |=> pend_nib_q == $past(addr_in[2]))
        else $error("nibble select lost");

    a_loop_on_lat: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && !loop_off_q |=> delay_q == $past({1'b0, al_q} + {1'b0, cl_q}))
        else $error("loop-on read latency wrong");

    a_loop_off_lat: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w && loop_off_q |=> delay_q == $past({1'b0, al_q} + {1'b0, cl_q}) - 5'h1)
        else $error("loop-off read latency wrong");

    a_readout_source: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_read_w |=> pend_readout_q == $past(readout_q))
        else $error("read source not taken");

    a_lane_bit_copy: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !dq_oe_n_out && pend_readout_q |-> dq_out == {16{dq_out[0]}})
        else $error("lane bits differ");

    a_deselect_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_n_in |=> !array_read_out && !array_write_out && !precharge_out)
        else $error("strobe while deselected");

    a_nop_no_mode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sel_w && cmd_w == dcr_pkg::CMD_NOP |=> $stable(cl_q) && $stable(bl_q))
        else $error("mode changed on no-operation");

    a_burst_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        beats_q != 4'h0 |=> !dq_oe_n_out)
        else $error("burst beat not driven");

    a_write_blocked: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        is_write_w && readout_q |=> !array_write_out)
        else $error("write reached array in readout");

    a_idle_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        dq_oe_n_out |-> dq_out == 16'h0000)
        else $error("data while not driving");

endmodule : dcr_readout

/* File: tb/dcr_ctrl_model.sv */
`timescale 1ns/100ps
module dcr_ctrl_model (
    // Clock
    input  wire logic        ref_clk_in,
    // Command bus
    output logic             cs_n_out,
    output logic [2:0]       cmd_out,
    output logic [2:0]       bank_out,
    output logic [13:0]      addr_out
);
    initial begin
        cs_n_out = 1'b1;
        cmd_out  = 3'h7;
        bank_out = 3'h0;
        addr_out = 14'h0000;
    end
    // One command for one cycle, then deselect with noise on the other lines
    task automatic issue(input logic s, input logic [2:0] c, input logic [2:0] b,
                         input logic [13:0] a);
        @(posedge ref_clk_in);
        cs_n_out <= s;
        cmd_out  <= c;
        bank_out <= b;
        addr_out <= a;
        @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        cmd_out  <= 3'($urandom);
        bank_out <= 3'($urandom);
        addr_out <= 14'($urandom);
    endtask : issue
    // Readout read with random bank and free address bits
    task automatic rd_readout(input logic nib, input logic a12);
        logic [13:0] a;
        a = 14'($urandom);
        a[1:0] = 2'h0;
        a[2] = nib;
        a[12] = a12;
        issue(1'b0, dcr_pkg::CMD_READ, 3'($urandom), a);
    endtask : rd_readout
endmodule : dcr_ctrl_model

/* File: tb/dcr_readout_bench.sv */
`timescale 1ns/100ps
module dcr_readout_bench;
    logic        ref_clk_in, rst_n_in, cs_n, dq_oe_n_out, array_read_out;
    logic        array_write_out, precharge_out, readout_en_out, loop_off_out;
    logic [2:0]  cmd, bank, seen;
    logic [13:0] addr;
    logic [15:0] array_data, dq_out;
    logic [1:0]  readout_loc_out;
    logic [3:0]  cas_lat_out, add_lat_out;
    int          bad_count = 0;
    int          n_tests = 0;
    int          md[6] = '{0, 1, 1, 1, 2, 2};
    int          bt[6] = '{8, 8, 4, 4, 4, 4};
    logic        nb[6] = '{0, 0, 0, 1, 0, 1};
    logic        ch[6] = '{1, 1, 0, 0, 1, 1};
    dcr_ctrl_model dcr_ctrl_model_inst (.ref_clk_in(ref_clk_in), .cs_n_out(cs_n),
        .cmd_out(cmd), .bank_out(bank), .addr_out(addr));
    dcr_readout dcr_readout_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]),
        .bank_in(bank), .addr_in(addr), .array_data_in(array_data), .dq_out(dq_out),
        .dq_oe_n_out(dq_oe_n_out), .array_read_out(array_read_out),
        .array_write_out(array_write_out), .precharge_out(precharge_out),
        .readout_en_out(readout_en_out), .readout_loc_out(readout_loc_out),
        .loop_off_out(loop_off_out), .cas_lat_out(cas_lat_out), .add_lat_out(add_lat_out));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) array_data <= 16'($urandom);
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic mode_set_command(input logic [2:0] b, input logic [13:0] a);
        dcr_ctrl_model_inst.issue(1'b0, dcr_pkg::CMD_MRS, b, a);
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask : mode_set_command
    // Read, one no-operation, then latency and every beat driven; readout beats against the model queue
    task automatic rd_check(input int lat, input int beats, input logic nib,
                            input logic a12, input logic ro);
        int          k;
        logic [15:0] q[$];
        q = {};
        for (int i = 0; i < beats; i++) q.push_back(((i + (nib ? 4 : 0)) % 2) ? 16'hffff : 16'h0);
        if (ro) dcr_ctrl_model_inst.rd_readout(nib, a12);
        else dcr_ctrl_model_inst.issue(1'b0, dcr_pkg::CMD_READ, 3'h0, 14'h1000);
        dcr_ctrl_model_inst.issue(1'b0, dcr_pkg::CMD_NOP, 3'h0, 14'h0000);
        #1;
        k = 2;
        while (dq_oe_n_out === 1'b1 && k < 40) begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end
        if (k >= 40) begin
            bad_count++;
            give_verdict();
        end
        check(k === lat + 1, "read latency");
        for (int i = 0; i < beats; i++) begin
            check(dq_oe_n_out === 1'b0 && (!ro || (dq_out === q[i] && array_read_out === 1'b0
                  && precharge_out === 1'b0)), "read beat");
            @(posedge ref_clk_in);
            #1;
        end
        check(dq_oe_n_out === 1'b1, "burst end");
    endtask : rd_check
    initial begin
        void'($urandom(32'h9b2e5c3c));
        rst_n_in = 1'b0;
        array_data = 16'h0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1;
        check(dq_oe_n_out === 1'b1 && cas_lat_out === 4'h6 && add_lat_out === 4'h0
              && readout_en_out === 1'b0 && loop_off_out === 1'b0, "reset values");
        mode_set_command(dcr_pkg::MR_THREE, 14'($urandom) & 14'h0003);
        for (int i = 0; i < 3; i++) begin
            dcr_ctrl_model_inst.issue(1'b0, i == 2 ? dcr_pkg::CMD_WRITE : dcr_pkg::CMD_READ,
                3'($urandom), i == 1 ? 14'h0400 : 14'h0000);
            seen = 3'h0;
            repeat (3) begin
                #1;
                seen |= {array_read_out, array_write_out, precharge_out};
                @(posedge ref_clk_in);
            end
            check(seen === (i == 0 ? 3'h4 : i == 1 ? 3'h5 : 3'h2), "array access");
            repeat (12) @(posedge ref_clk_in);
        end
        $display("test normal mode done");
        for (int c = 0; c < 6; c++) begin
            mode_set_command(dcr_pkg::MR_ZERO, 14'h0020 | 14'(md[c]));
            mode_set_command(dcr_pkg::MR_THREE, 14'h0004);
            check(readout_en_out === 1'b1 && readout_loc_out === 2'h0, "enable");
            rd_check(6, bt[c], nb[c], ch[c], 1'b1);
            mode_set_command(dcr_pkg::MR_THREE, 14'h0000);
            $display("test readout case %0d done", c);
        end
        mode_set_command(dcr_pkg::MR_ZERO, 14'h0020);
        rd_check(6, 8, 1'b0, 1'b1, 1'b0);
        mode_set_command(dcr_pkg::MR_ONE, 14'h0009);
        check(loop_off_out === 1'b1 && cas_lat_out === 4'h6 && add_lat_out === 4'h5,
              "loop off");
        mode_set_command(dcr_pkg::MR_ZERO, 14'h0040);
        check(cas_lat_out === 4'h6, "loop-off latency");
        rd_check(10, 8, 1'b0, 1'b1, 1'b0);
        mode_set_command(dcr_pkg::MR_ONE, 14'h0000);
        check(loop_off_out === 1'b0, "loop on");
        $display("test loop off done");
        mode_set_command(dcr_pkg::MR_THREE, 14'h0004);
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1;
        check(readout_en_out === 1'b0 && dq_oe_n_out === 1'b1, "reset in readout");
        $display("test reset done");
        give_verdict();
    end
endmodule : dcr_readout_bench
